// ==== rtl/tacp_defs.vh ====
// Purpose: constants for the thermometer ascii command parser
// Assumes: 250 MHz clock
// Notes: characters are ascii codes
`ifndef TACP_DEFS_VH
`define TACP_DEFS_VH

`define TACP_CHAR_ACK       8'h21
`define TACP_CHAR_NAK       8'h2a
`define TACP_CHAR_QUERY     8'h3f
`define TACP_CHAR_SET       8'h3d
`define TACP_CHAR_CR        8'h0d
`define TACP_CHAR_LF        8'h0a
`define TACP_CHAR_DOT       8'h2e
`define TACP_CHAR_ZERO      8'h30
`define TACP_CHAR_NINE      8'h39
`define TACP_CHAR_BAUD      8'h44
`define TACP_CHAR_VALLEY    8'h46
`define TACP_CHAR_AVG       8'h47
`define TACP_CHAR_RELAY     8'h4b
`define TACP_CHAR_THRESH    8'h43
`define TACP_CHAR_LOWA      8'h61
`define TACP_CHAR_LOWZ      8'h7a
`define TACP_LINE_MAX       4'hc

`define TACP_RST_BAUD       12'h384
`define TACP_RST_TIME       16'h0000
`define TACP_RST_RELAY      2'h2
`define TACP_RST_THRESH     16'h0000
`define TACP_TIME_MAX       16'h3000
`define TACP_VALLEY_ADV     16'h3000
`define TACP_THRESH_MAX_C   16'h3000
`define TACP_THRESH_MAX_F   16'h5432

`define TACP_CLK_MHZ        250
`define TACP_POLL_LIMIT_S   4
`define TACP_BURST_LIMIT_S  8
`define TACP_POLL_LIMIT_CYC  (`TACP_POLL_LIMIT_S * `TACP_CLK_MHZ * 1000000)
`define TACP_BURST_LIMIT_CYC (`TACP_BURST_LIMIT_S * `TACP_CLK_MHZ * 1000000)

`endif

// ==== rtl/tacp_resp_tx.v ====
// Purpose: sends a response string one byte per handshake
// Assumes: host accepts bytes with txReady
// Notes: optional 3-digit address ahead of the ack mark
`timescale 1ns/1ps
`include "tacp_defs.vh"

module tacp_resp_tx (
    input  wire        clock,
    input  wire        resetn,
    input  wire        start,
    input  wire        isAck,
    input  wire        withAddr,
    input  wire [11:0] addrBcd,
    input  wire [31:0] payload,
    input  wire [2:0]  payloadLen,
    output wire        busy,
    output reg  [7:0]  txData,
    output wire        txValid,
    input  wire        txReady
);
    reg [3:0]  step;
    reg [3:0]  lastStep;
    reg        active;
    reg        ack;
    reg        addr;
    reg [11:0] addrHold;
    reg [31:0] data;

    function [7:0] digit;
        input [3:0] nib;
        digit = `TACP_CHAR_ZERO + {4'h0, nib};
    endfunction

    always @* begin
        txData = `TACP_CHAR_NAK;
        if (!ack) txData = `TACP_CHAR_NAK;
        else if (addr && step < 4'h3) txData = digit(addrHold[11 - 4 * step[1:0] -: 4]);
        else if (step == 4'h3) txData = `TACP_CHAR_ACK;
        else txData = data[31 - 8 * (step[2:0] - 3'h4) -: 8];
    end

    assign txValid = active;
    assign busy    = active;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            active   <= 1'b0;
            step     <= 4'h0;
            lastStep <= 4'h0;
            ack      <= 1'b0;
            addr     <= 1'b0;
            addrHold <= 12'h000;
            data     <= 32'h00000000;
        end else if (start && !active) begin
            active   <= 1'b1;
            ack      <= isAck;
            addr     <= withAddr;
            addrHold <= addrBcd;
            data     <= payload;
            step     <= !isAck ? 4'h0 : (withAddr ? 4'h0 : 4'h3);
            lastStep <= !isAck ? 4'h0 : 4'h3 + {1'b0, payloadLen};
        end else if (active && txReady) begin
            if (step == lastStep) active <= 1'b0;
            else step <= step + 4'h1;
        end
    end
endmodule // tacp_resp_tx

// ==== rtl/tacp_parser.v ====
// Purpose: ascii command interpreter for a thermometer serial link
// Assumes: received bytes arrive one per rxValid pulse, synchronous to clock
// Notes: numeric fields held as bcd digits; only D F G K C parameters kept
`timescale 1ns/1ps
`include "tacp_defs.vh"

module tacp_parser (
    input  wire        clock,
    input  wire        resetn,
    input  wire [7:0]  rxData,
    input  wire        rxValid,
    input  wire        rxBroadcast,
    input  wire        multidropOn,
    input  wire        addrEcho,
    input  wire [11:0] stationAddr,
    input  wire        burstMode,
    input  wire        scaleFahrenheit,
    output wire [7:0]  txData,
    output wire        txValid,
    input  wire        txReady,
    output wire        cmdBusy,
    output reg  [11:0] baudCode,
    output reg         baudRestart,
    output reg  [15:0] averageTime,
    output reg  [15:0] valleyTime,
    output reg         valleyAdvanced,
    output reg         peakHoldCancel,
    output reg  [1:0]  relayMode,
    output reg  [15:0] holdThreshold,
    output reg         responseLate
);
    localparam ST_RECV = 3'b001;
    localparam ST_EVAL = 3'b010;
    localparam ST_SEND = 3'b100;

    reg [2:0]  state;
    reg [7:0]  line [0:11];
    reg [3:0]  count;
    reg        overflow;
    reg        startTx;
    reg        ackTx;
    reg [31:0] payload;
    reg [2:0]  payLen;
    reg [31:0] waitCount;
    reg        next_ok;
    reg [15:0] next_val;
    reg [31:0] next_pay;
    reg [2:0]  next_len;
    wire       txBusy;
    integer    i;

    function isDigit;
        input [7:0] c;
        isDigit = (c >= `TACP_CHAR_ZERO) && (c <= `TACP_CHAR_NINE);
    endfunction

    function [3:0] nib;
        input [7:0] c;
        nib = c[3:0];
    endfunction

    // four bcd digits from nnnn or nnn.n starting at index 2
    function [15:0] field4;
        input dotted;
        input [7:0] a, b, c, d, e;
        field4 = dotted ? {nib(a), nib(b), nib(c), nib(e)} : {nib(a), nib(b), nib(c), nib(d)};
    endfunction

    always @* begin
        next_ok  = 1'b0;
        next_val = 16'h0000;
        next_pay = 32'h00000000;
        next_len = 3'h0;
        for (i = 0; i < 12; i = i + 1)
            if (i < count && line[i] >= `TACP_CHAR_LOWA && line[i] <= `TACP_CHAR_LOWZ)
                next_len = 3'h7;
        if (next_len == 3'h7 || overflow) begin
            next_ok  = 1'b0;
            next_len = 3'h0;
        end else if (count == 4'h2 && line[1] == `TACP_CHAR_QUERY) begin
            next_ok = 1'b1;
            case (line[0])
                `TACP_CHAR_BAUD:   begin next_pay = {line[0], 8'h3d, 4'h3, baudCode[11:8], 4'h3, baudCode[7:4]}; next_len = 3'h4; end
                `TACP_CHAR_RELAY:  begin next_pay = {line[0], 8'h3d, 6'h0c, relayMode, 8'h00}; next_len = 3'h3; end
                `TACP_CHAR_VALLEY: begin next_pay = {line[0], 4'h3, valleyTime[15:12], 4'h3, valleyTime[11:8], 4'h3, valleyTime[7:4]}; next_len = 3'h4; end
                `TACP_CHAR_AVG:    begin next_pay = {line[0], 4'h3, averageTime[15:12], 4'h3, averageTime[11:8], 4'h3, averageTime[7:4]}; next_len = 3'h4; end
                `TACP_CHAR_THRESH: begin next_pay = {line[0], 4'h3, holdThreshold[15:12], 4'h3, holdThreshold[11:8], 4'h3, holdThreshold[7:4]}; next_len = 3'h4; end
                default:           next_ok = 1'b0;
            endcase
        end else if (count >= 4'h3 && line[1] == `TACP_CHAR_SET) begin
            next_pay = {line[0], `TACP_CHAR_SET, 16'h0000};
            next_len = 3'h2;
            case (line[0])
                `TACP_CHAR_BAUD: begin
                    next_val = {nib(line[2]), nib(line[3]), nib(line[4])} & 16'h0fff;
                    next_ok = count == 4'h5 && isDigit(line[2]) && isDigit(line[3]) && isDigit(line[4])
                        && !rxBroadcast
                        && (next_val == 16'h0003 || next_val == 16'h0012 || next_val == 16'h0024
                        || next_val == 16'h0096 || next_val == 16'h0192 || next_val == 16'h0384);
                end
                `TACP_CHAR_VALLEY, `TACP_CHAR_AVG: begin
                    next_val = field4(1'b1, line[2], line[3], line[4], line[5], line[6]);
                    next_ok = count == 4'h7 && isDigit(line[2]) && isDigit(line[3])
                        && isDigit(line[4]) && line[5] == `TACP_CHAR_DOT && isDigit(line[6])
                        && next_val <= `TACP_TIME_MAX;
                end
                `TACP_CHAR_THRESH: begin
                    next_val = field4(1'b0, line[2], line[3], line[4], line[5], 8'h30);
                    next_ok = count == 4'h6 && isDigit(line[2]) && isDigit(line[3])
                        && isDigit(line[4]) && isDigit(line[5])
                        && next_val <= (scaleFahrenheit ? `TACP_THRESH_MAX_F : `TACP_THRESH_MAX_C);
                end
                `TACP_CHAR_RELAY: begin
                    next_val = {12'h000, nib(line[2])};
                    next_ok = count == 4'h3 && line[2] >= `TACP_CHAR_ZERO
                        && line[2] <= 8'h33;
                end
                default: next_ok = 1'b0;
            endcase
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state          <= ST_RECV;
            count          <= 4'h0;
            overflow       <= 1'b0;
            startTx        <= 1'b0;
            ackTx          <= 1'b0;
            payload        <= 32'h00000000;
            payLen         <= 3'h0;
            baudCode       <= `TACP_RST_BAUD;
            baudRestart    <= 1'b0;
            averageTime    <= `TACP_RST_TIME;
            valleyTime     <= `TACP_RST_TIME;
            valleyAdvanced <= 1'b0;
            peakHoldCancel <= 1'b0;
            relayMode      <= `TACP_RST_RELAY;
            holdThreshold  <= `TACP_RST_THRESH;
            waitCount      <= 32'h00000000;
            responseLate   <= 1'b0;
        end else begin
            startTx        <= 1'b0;
            baudRestart    <= 1'b0;
            peakHoldCancel <= 1'b0;
            case (state)
                ST_RECV: begin
                    waitCount <= 32'h00000000;
                    if (rxValid) begin
                        if (rxData == `TACP_CHAR_CR || rxData == `TACP_CHAR_LF) begin
                            if (count != 4'h0 || overflow) state <= ST_EVAL;
                        end else if (count == `TACP_LINE_MAX) begin
                            overflow <= 1'b1;
                        end else begin
                            line[count] <= rxData;
                            count <= count + 4'h1;
                        end
                    end
                end
                ST_EVAL: begin
                    ackTx   <= next_ok;
                    payload <= next_pay;
                    payLen  <= next_len;
                    startTx <= 1'b1;
                    state   <= ST_SEND;
                    if (next_ok && line[1] == `TACP_CHAR_SET) begin
                        case (line[0])
                            `TACP_CHAR_BAUD: begin
                                baudCode    <= next_val[11:0];
                                baudRestart <= 1'b1;
                            end
                            `TACP_CHAR_AVG: begin
                                averageTime    <= next_val;
                                valleyTime     <= `TACP_RST_TIME;
                                valleyAdvanced <= 1'b0;
                                peakHoldCancel <= 1'b1;
                            end
                            `TACP_CHAR_VALLEY: begin
                                valleyTime     <= next_val;
                                valleyAdvanced <= next_val == `TACP_VALLEY_ADV;
                                averageTime    <= `TACP_RST_TIME;
                                peakHoldCancel <= 1'b1;
                            end
                            `TACP_CHAR_THRESH: holdThreshold <= next_val;
                            `TACP_CHAR_RELAY:  relayMode <= next_val[1:0];
                            default: ;
                        endcase
                    end
                end
                ST_SEND: begin
                    waitCount <= waitCount + 32'h00000001;
                    if (waitCount >= (burstMode ? `TACP_BURST_LIMIT_CYC : `TACP_POLL_LIMIT_CYC))
                        responseLate <= 1'b1;
                    if (!startTx && !txBusy) begin
                        count    <= 4'h0;
                        overflow <= 1'b0;
                        state    <= ST_RECV;
                    end
                end
                default: state <= ST_RECV;
            endcase
        end
    end

    assign cmdBusy = state != ST_RECV;

    tacp_resp_tx u_tx (
        .clock      (clock),
        .resetn     (resetn),
        .start      (startTx),
        .isAck      (ackTx),
        .withAddr   (multidropOn && addrEcho),
        .addrBcd    (stationAddr),
        .payload    (payload),
        .payloadLen (payLen),
        .busy       (txBusy),
        .txData     (txData),
        .txValid    (txValid),
        .txReady    (txReady)
    );
endmodule // tacp_parser

// ==== bench/tacp_parser_properties.sv ====
// Purpose: port checks for the command parser
// Assumes: one clock, async active-low reset
// Notes: bound to every parser instance
`timescale 1ns/1ps
module tacp_parser_properties (
    input wire        clock,
    input wire        resetn,
    input wire [7:0]  rxData,
    input wire        rxValid,
    input wire        rxBroadcast,
    input wire [7:0]  txData,
    input wire        txValid,
    input wire        txReady,
    input wire        cmdBusy,
    input wire [11:0] baudCode,
    input wire        baudRestart,
    input wire [15:0] averageTime,
    input wire [15:0] valleyTime,
    input wire        valleyAdvanced,
    input wire [1:0]  relayMode,
    input wire [15:0] holdThreshold
);
    reg  [4:0] lineLen;
    wire       isTerm = rxValid && !cmdBusy && (rxData == 8'h0d || rxData == 8'h0a);
    // counts bytes of the line in progress, saturating
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            lineLen <= 5'h00;
        else if (rxValid && !cmdBusy)
            lineLen <= isTerm ? 5'h00 : (lineLen == 5'h1f ? lineLen : lineLen + 5'h01);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence termTaken;
        isTerm && lineLen != 5'h00;
    endsequence
    sequence answerStarts;
        !txValid ##[1:3] txValid;
    endsequence
    answer_follows_a: assert property (termTaken |-> answerStarts)
        else $error("no answer after line");
    tx_holds_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("byte dropped");
    nak_single_a: assert property (txValid && txReady && txData == 8'h2a |=> !txValid)
        else $error("nak not alone");
    idle_quiet_a: assert property (!cmdBusy |-> !txValid)
        else $error("stray byte");
    baud_restart_a: assert property (baudRestart |-> !$past(rxBroadcast) ##1 !baudRestart)
        else $error("bad restart");
    param_frozen_a: assert property (!cmdBusy |=> $stable(baudCode) && $stable(relayMode))
        else $error("early change");
    valley_cancel_a: assert property ($changed(valleyTime) && valleyTime != 16'h0000
        |-> averageTime == 16'h0000)
        else $error("average kept");
    valley_adv_a: assert property (!cmdBusy |-> valleyAdvanced == (valleyTime == 16'h3000))
        else $error("advanced flag wrong");
    field_range_a: assert property (valleyTime <= 16'h3000 && holdThreshold <= 16'h5432)
        else $error("field out of range");
endmodule // tacp_parser_properties

bind tacp_parser tacp_parser_properties chk (.clock(clock), .resetn(resetn), .rxData(rxData),
    .rxValid(rxValid), .rxBroadcast(rxBroadcast), .txData(txData), .txValid(txValid),
    .txReady(txReady), .cmdBusy(cmdBusy), .baudCode(baudCode), .baudRestart(baudRestart),
    .averageTime(averageTime), .valleyTime(valleyTime), .valleyAdvanced(valleyAdvanced),
    .relayMode(relayMode), .holdThreshold(holdThreshold));

// ==== bench/tacp_host_model.sv ====
// Purpose: host side of the command link
// Assumes: one command in flight
// Notes: slow makes txReady toggle
`timescale 1ns/1ps
module tacp_host_model (
    input  wire       clock,
    input  wire       slow,
    input  wire [7:0] txData,
    input  wire       txValid,
    input  wire       cmdBusy,
    output reg  [7:0] rxData,
    output reg        rxValid,
    output reg        txReady
);
    string resp;
    initial begin
        rxData = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b1;
    end
    always @(posedge clock) begin
        if (txValid && txReady)
            resp <= $sformatf("%s%c", resp, txData);
        txReady <= slow ? !txReady : 1'b1;
    end
    // full-width fields as given, one line, then wait for the answer
    task automatic send(input string c);
        int i;
        resp = "";
        for (i = 0; i <= c.len(); i++) begin
            @(posedge clock);
            rxData <= (i == c.len()) ? 8'h0d : c[i];
            rxValid <= 1'b1;
        end
        @(posedge clock);
        rxValid <= 1'b0;
        rxData <= ~rxData;
        @(negedge clock);
        for (i = 0; i < 4000 && (cmdBusy !== 1'b0 || txValid !== 1'b0); i++)
            @(negedge clock);
        @(posedge clock);
    endtask
endmodule // tacp_host_model

// ==== bench/tacp_parser_tb.sv ====
// Purpose: self-checking bench for the command parser
// Assumes: 250 MHz clock
// Notes: commands sent through the host model
`timescale 1ns/1ps
module tacp_parser_tb;
    reg         clock = 1'b0, resetn = 1'b0, slow = 1'b0, rxBroadcast = 1'b0;
    reg         multidropOn = 1'b0, addrEcho = 1'b0, scaleFahrenheit = 1'b0, burstMode = 1'b0;
    reg  [11:0] stationAddr = 12'h000;
    wire [7:0]  rxData, txData;
    wire        rxValid, txValid, txReady, cmdBusy, baudRestart, valleyAdvanced;
    wire        peakHoldCancel, responseLate;
    wire [11:0] baudCode;
    wire [15:0] averageTime, valleyTime, holdThreshold;
    wire [1:0]  relayMode;
    int         miscompares = 0, nCompared = 0, i, restarts = 0, cancels = 0;
    always #2 clock = ~clock;
    tacp_parser dut (.clock(clock), .resetn(resetn), .rxData(rxData), .rxValid(rxValid),
        .rxBroadcast(rxBroadcast), .multidropOn(multidropOn), .addrEcho(addrEcho),
        .stationAddr(stationAddr), .burstMode(burstMode), .scaleFahrenheit(scaleFahrenheit),
        .txData(txData), .txValid(txValid), .txReady(txReady), .cmdBusy(cmdBusy),
        .baudCode(baudCode), .baudRestart(baudRestart), .averageTime(averageTime),
        .valleyTime(valleyTime), .valleyAdvanced(valleyAdvanced),
        .peakHoldCancel(peakHoldCancel), .relayMode(relayMode),
        .holdThreshold(holdThreshold), .responseLate(responseLate));
    tacp_host_model host (.clock(clock), .slow(slow), .txData(txData), .txValid(txValid),
        .cmdBusy(cmdBusy), .rxData(rxData), .rxValid(rxValid), .txReady(txReady));
    always @(posedge clock) begin
        if (baudRestart) restarts++;
        if (peakHoldCancel) cancels++;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [63:0] pk(input string s);
        pk = 64'h0;
        for (int k = 0; k < s.len(); k++)
            pk = {pk[55:0], s[k]};
    endfunction
    task automatic cmd(input string c, input string exp);
        host.send(c);
        check(pk(host.resp), pk(exp));
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && nCompared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        check(64'(baudCode), 64'h384);
        check(64'(relayMode), 64'h2);
        check(64'(valleyTime | averageTime | holdThreshold), 64'h0);
    endtask
    task automatic t_relay();
        slow <= 1'b1;
        for (i = 0; i < 4; i++) begin
            cmd($sformatf("K=%0d", i), "!K=");
            check(64'(relayMode), 64'(i));
        end
        cmd("K?", "!K=3");
        slow <= 1'b0;
    endtask
    task automatic t_illegal();
        string bad[7] = '{"K=4", "k=1", "F=12.3", "G=300.1", "Z?", "K=11111111111111", "D=100"};
        foreach (bad[j])
            cmd(bad[j], "*");
        check(64'(relayMode), 64'h3);
        check(64'(averageTime | valleyTime), 64'h0);
        check(64'(baudCode), 64'h384);
    endtask
    task automatic t_baud();
        cmd("D=096", "!D=");
        check(64'(baudCode), 64'h096);
        rxBroadcast <= 1'b1;
        cmd("D=003", "*");
        rxBroadcast <= 1'b0;
        cmd("D?", "!D=09");
        check(64'(restarts), 64'h1);
    endtask
    task automatic t_hold();
        cmd("F=001.0", "!F=");
        cmd("G=123.4", "!G=");
        check(64'({averageTime, valleyTime}), 64'h12340000);
        cmd("F=300.0", "!F=");
        check(64'({averageTime, valleyTime}), 64'h00003000);
        check(64'(valleyAdvanced), 64'h1);
        cmd("F?", "!F300");
        check(64'(cancels), 64'h3);
    endtask
    task automatic t_thresh();
        cmd("C=3000", "!C=");
        cmd("C=3001", "*");
        check(64'(holdThreshold), 64'h3000);
        scaleFahrenheit <= 1'b1;
        cmd("C=5432", "!C=");
        cmd("C=5433", "*");
        check(64'(holdThreshold), 64'h5432);
        cmd("C=0000", "!C=");
        scaleFahrenheit <= 1'b0;
    endtask
    task automatic t_addr();
        multidropOn <= 1'b1;
        addrEcho <= 1'b1;
        stationAddr <= 12'h017;
        burstMode <= 1'b1;
        cmd("K=2", "017!K=");
        cmd("K=9", "*");
        addrEcho <= 1'b0;
        cmd("K=2", "!K=");
        multidropOn <= 1'b0;
        burstMode <= 1'b0;
        check(64'(responseLate), 64'h0);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_relay();
        t_illegal();
        t_baud();
        t_hold();
        t_thresh();
        t_addr();
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
endmodule // tacp_parser_tb
